// *** sve_pkg.sv ***
// constants, opcode fields and state codes of the sign-mode / vectored-call / xor executor
package sve_pkg;
   localparam int unsigned DW        = 16;
   localparam int unsigned NACC      = 32;
   localparam int unsigned NREG      = 8;
   localparam logic [15:0] PC_RST    = 16'h0000;
   localparam logic [15:0] STAT_RST  = 16'h0000;
   localparam logic [15:0] REG_RST   = 16'h0000;
   localparam logic [4:0]  PT_RST    = 5'h00;
   localparam logic [15:0] VEC_BASE  = 16'h7f00;
   localparam logic [15:0] SP_STEP   = 16'h0002;
   localparam logic [15:0] POST_STEP = 16'h0002;
   localparam logic [4:0]  ACC_OFS   = 5'h10;
   localparam logic [2:0]  SP_IDX    = 3'h7;
   localparam logic [2:0]  OFS_IDX   = 3'h5;
   localparam logic [15:0] ONE_WORD  = 16'h0001;
   localparam logic [15:0] TWO_WORDS = 16'h0002;
   // status word bit positions
   localparam int ST_SX  = 0;
   localparam int ST_OVF = 1;
   localparam int ST_SGN = 2;
   localparam int ST_ZER = 3;
   localparam int ST_CRY = 4;
   localparam int ST_TAG = 5;
   localparam int ST_TFA = 6;
   localparam int ST_TFB = 7;
   // opcodes and opcode fields
   localparam logic [16:0] SET_SX_OPC = 17'h0_0001;
   localparam logic [16:0] CLR_SX_OPC = 17'h0_0002;
   localparam logic [8:0]  VECTORED_CALL_INSTR_PFX  = 9'h1fd;
   localparam logic [6:0]  XMEM_PFX   = 7'h24;
   localparam logic [4:0]  XACC_PFX   = 5'h1c;
   localparam logic [5:0]  XIMM_SUB   = 6'h31;
   localparam logic [5:0]  XAA_SUB    = 6'h10;
   localparam logic [4:0]  XTFM_PFX   = 5'h13;
   localparam logic [2:0]  XTFM_SUB   = 3'h6;
   localparam logic [4:0]  XTFC_PFX   = 5'h12;
   localparam logic [1:0]  XTFC_SUB   = 2'h3;
   localparam logic [1:0]  NXT_INC    = 2'h1;
   localparam logic [1:0]  NXT_DEC    = 2'h2;
   // memory operand modes
   localparam logic [2:0]  AM_DIRECT  = 3'h0;
   localparam logic [2:0]  AM_IND     = 3'h1;
   localparam logic [2:0]  AM_POSTINC = 3'h2;
   localparam logic [2:0]  AM_POSTDEC = 3'h3;
   localparam logic [2:0]  AM_INDEXED = 3'h4;
   // condition codes
   localparam logic [4:0]  CC_TRUE = 5'h00;
   localparam logic [4:0]  CC_CRY  = 5'h01;
   localparam logic [4:0]  CC_ZER  = 5'h02;
   localparam logic [4:0]  CC_SGN  = 5'h03;
   localparam logic [4:0]  CC_OVF  = 5'h04;
   localparam logic [4:0]  CC_TAG  = 5'h05;
   localparam logic [4:0]  CC_RZ   = 5'h06;
   localparam logic [4:0]  CC_RNZ  = 5'h07;
   localparam logic [4:0]  CC_RN   = 5'h08;
   localparam logic [4:0]  CC_RNN  = 5'h09;
   // pending operation kinds
   localparam logic [1:0]  K_MEM = 2'h0;
   localparam logic [1:0]  K_TFM = 2'h1;
   localparam logic [1:0]  K_VEC = 2'h2;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_REQ  = 4'b0010,
      ST_MDAT = 4'b0100,
      ST_VDAT = 4'b1000
   } sve_state_t;
endpackage : sve_pkg

// *** sve_exec.sv ***
// executor for set/clear sign mode, vectored call and the xor instruction family
`timescale 1ns/1ps
// How it works
// - the set-sign-mode instruction writes 1 to status bit 0 and leaves condition flags alone.
// - while status bit 0 is 1 the sign-extension mode output stays high for arithmetic.
// - a vectored call pushes the next address and moves the stack pointer register up by 2.
// - a vectored call loads the program counter with the program word at 0x7F00 plus vector.
// - a vectored call is one program word long.
// - xor writes destination xor source, or source xor second source, to the destination.
// - xor into an accumulator sets overflow, sign, zero, carry; a memory source also sets tag.
// - test-flag xor with a flag address folds the memory tag into the chosen test flag.
// - test-flag xor with a condition folds it in; an index register only for index tests.
// - the index-zero condition is true exactly when the chosen index register holds zero.
// - the next-accumulator option steps the accumulator pointer before operands are read.
// - a post-decrement memory operand lowers its index register by 2 after taking the address, before the xor.
// - an indexed base-plus-offset operand leaves the base register unchanged.
module sve_exec
   import sve_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        arst_n,
   input  wire logic        ce,
   input  wire logic        instr_valid,
   input  wire logic [16:0] instr_word,
   input  wire logic [15:0] instr_ext,
   input  wire logic [15:0] pmem_rdata,
   input  wire logic [15:0] dmem_rdata,
   input  wire logic        dmem_tag,
   output logic             busy_r,
   output logic             done_r,
   output logic [15:0]      pc_r,
   output logic [15:0]      stat_r,
   output logic             sign_ext_mode_r,
   output logic [15:0]      result_r,
   output logic [15:0]      pmem_addr_r,
   output logic             pmem_rd_r,
   output logic [15:0]      dmem_addr_r,
   output logic             dmem_rd_r,
   output logic             dmem_wr_r,
   output logic [15:0]      dmem_wdata_r
);
   sve_state_t  st_r, st_nxt;
   logic [15:0] acc_r [NACC];
   logic [15:0] rx_r  [NREG];
   logic [4:0]  pt_r  [4];
   logic [15:0] pc_nxt, stat_nxt, result_nxt, opa_r, opa_nxt, pw_r, pw_nxt;
   logic [15:0] pmem_addr_nxt, dmem_addr_nxt, dmem_wdata_nxt;
   logic        pmem_rd_nxt, dmem_rd_nxt, dmem_wr_nxt, done_nxt;
   logic [1:0]  kind_r, kind_nxt;
   logic [4:0]  dst_r, dst_nxt;
   logic        tfs_r, tfs_nxt;
   logic        acc_we, rx_we, pt_we;
   logic [4:0]  acc_wa, pt_wd;
   logic [2:0]  rx_wa;
   logic [1:0]  pt_wa;
   logic [15:0] acc_wd, rx_wd;
   // decode fields
   logic        accept;
   logic [1:0]  an, nxt_opt;
   logic [4:0]  apm, cc;
   logic [2:0]  am, rb, rsel;
   logic        cond;

   assign accept  = ce && instr_valid && (st_r == ST_IDLE);
   assign an      = instr_word[9:8];
   assign nxt_opt = instr_word[11:10];
   assign am      = instr_word[7:5];
   assign rb      = instr_word[2:0];
   assign cc      = instr_word[9:5];
   assign rsel    = instr_word[4:2];

   // pointer premodify happens before any accumulator is read
   always_comb begin
      apm = pt_r[an];
      if (nxt_opt == NXT_INC) begin
         apm = pt_r[an] + 5'h01;
      end else if (nxt_opt == NXT_DEC) begin
         apm = pt_r[an] - 5'h01;
      end
   end

   // condition evaluation; index tests read only the named index register
   always_comb begin
      unique case (cc)
         CC_TRUE: cond = 1'b1;
         CC_CRY:  cond = stat_r[ST_CRY];
         CC_ZER:  cond = stat_r[ST_ZER];
         CC_SGN:  cond = stat_r[ST_SGN];
         CC_OVF:  cond = stat_r[ST_OVF];
         CC_TAG:  cond = stat_r[ST_TAG];
         CC_RZ:   cond = (rx_r[rsel] == 16'h0000);
         CC_RNZ:  cond = (rx_r[rsel] != 16'h0000);
         CC_RN:   cond = rx_r[rsel][15];
         CC_RNN:  cond = !rx_r[rsel][15];
         default: cond = 1'b0;
      endcase
   end

   // next state of the sequencer, status, pc and memory strobes
   always_comb begin
      st_nxt = st_r;
      pc_nxt = pc_r;
      stat_nxt = stat_r;
      result_nxt = result_r;
      opa_nxt = opa_r;
      pw_nxt = pw_r;
      kind_nxt = kind_r;
      dst_nxt = dst_r;
      tfs_nxt = tfs_r;
      pmem_addr_nxt = pmem_addr_r;
      dmem_addr_nxt = dmem_addr_r;
      dmem_wdata_nxt = dmem_wdata_r;
      pmem_rd_nxt = 1'b0;
      dmem_rd_nxt = 1'b0;
      dmem_wr_nxt = 1'b0;
      done_nxt = 1'b0;
      acc_we = 1'b0;
      acc_wa = dst_r;
      acc_wd = 16'h0000;
      rx_we = 1'b0;
      rx_wa = rb;
      rx_wd = 16'h0000;
      pt_we = 1'b0;
      pt_wa = an;
      pt_wd = apm;
      unique case (st_r)
         ST_IDLE: begin
            if (accept) begin
               if (instr_word == SET_SX_OPC) begin
                  stat_nxt[ST_SX] = 1'b1;
                  pc_nxt = pc_r + ONE_WORD;
                  done_nxt = 1'b1;
               end else if (instr_word == CLR_SX_OPC) begin
                  stat_nxt[ST_SX] = 1'b0;
                  pc_nxt = pc_r + ONE_WORD;
                  done_nxt = 1'b1;
               end else if (instr_word[16:8] == VECTORED_CALL_INSTR_PFX) begin
                  // push next address at the stack pointer, then step it
                  dmem_addr_nxt = rx_r[SP_IDX];
                  dmem_wdata_nxt = pc_r + ONE_WORD;
                  dmem_wr_nxt = 1'b1;
                  rx_we = 1'b1;
                  rx_wa = SP_IDX;
                  rx_wd = rx_r[SP_IDX] + SP_STEP;
                  pmem_addr_nxt = VEC_BASE + {8'h00, instr_word[7:0]};
                  pmem_rd_nxt = 1'b1;
                  kind_nxt = K_VEC;
                  st_nxt = ST_REQ;
               end else if (instr_word[16:10] == XMEM_PFX) begin
                  dst_nxt = pt_r[an];
                  opa_nxt = acc_r[pt_r[an]];
                  pw_nxt = (am == AM_DIRECT) ? TWO_WORDS : ONE_WORD;
                  dmem_addr_nxt = rx_r[rb];
                  if (am == AM_DIRECT) begin
                     dmem_addr_nxt = instr_ext;
                  end else if (am == AM_INDEXED) begin
                     dmem_addr_nxt = rx_r[rb] + rx_r[OFS_IDX];   // base kept
                  end else if (am == AM_POSTINC) begin
                     rx_we = 1'b1;
                     rx_wd = rx_r[rb] + POST_STEP;
                  end else if (am == AM_POSTDEC) begin
                     rx_we = 1'b1;
                     rx_wd = rx_r[rb] - POST_STEP;
                  end
                  dmem_rd_nxt = 1'b1;
                  kind_nxt = K_MEM;
                  st_nxt = ST_REQ;
               end else if (instr_word[16:12] == XACC_PFX
                            && (instr_word[7:2] == XIMM_SUB || instr_word[7:2] == XAA_SUB)) begin
                  pt_we = 1'b1;
                  acc_wa = instr_word[0] ? (apm ^ ACC_OFS) : apm;
                  if (instr_word[7:2] == XIMM_SUB) begin
                     acc_wd = acc_r[instr_word[1] ? (apm ^ ACC_OFS) : apm] ^ instr_ext;
                     pc_nxt = pc_r + TWO_WORDS;
                  end else begin
                     acc_wd = acc_r[apm] ^ acc_r[apm ^ ACC_OFS];
                     pc_nxt = pc_r + ONE_WORD;
                  end
                  acc_we = 1'b1;
                  result_nxt = acc_wd;
                  // logic result: no carry or overflow out
                  stat_nxt[ST_OVF] = 1'b0;
                  stat_nxt[ST_CRY] = 1'b0;
                  stat_nxt[ST_SGN] = acc_wd[15];
                  stat_nxt[ST_ZER] = (acc_wd == 16'h0000);
                  done_nxt = 1'b1;
               end else if (instr_word[16:12] == XTFM_PFX && instr_word[9:7] == XTFM_SUB) begin
                  tfs_nxt = instr_word[11];
                  dmem_addr_nxt = {9'h000, instr_word[6:0]};
                  dmem_rd_nxt = 1'b1;
                  kind_nxt = K_TFM;
                  st_nxt = ST_REQ;
               end else if (instr_word[16:12] == XTFC_PFX && instr_word[1:0] == XTFC_SUB) begin
                  // not-bit inverts the condition before it is folded
                  if (instr_word[11]) begin
                     stat_nxt[ST_TFB] = stat_r[ST_TFB] ^ (cond ^ instr_word[10]);
                  end else begin
                     stat_nxt[ST_TFA] = stat_r[ST_TFA] ^ (cond ^ instr_word[10]);
                  end
                  pc_nxt = pc_r + ONE_WORD;
                  done_nxt = 1'b1;
               end
            end
         end
         ST_REQ: begin
            // strobe is at the memory now; data lands one cycle later
            if (ce) begin
               st_nxt = (kind_r == K_VEC) ? ST_VDAT : ST_MDAT;
            end
         end
         ST_MDAT: begin
            if (ce) begin
               if (kind_r == K_MEM) begin
                  acc_we = 1'b1;
                  acc_wd = opa_r ^ dmem_rdata;
                  result_nxt = acc_wd;
                  stat_nxt[ST_OVF] = 1'b0;
                  stat_nxt[ST_CRY] = 1'b0;
                  stat_nxt[ST_SGN] = acc_wd[15];
                  stat_nxt[ST_ZER] = (acc_wd == 16'h0000);
                  stat_nxt[ST_TAG] = dmem_tag;
                  pc_nxt = pc_r + pw_r;
               end else begin
                  if (tfs_r) begin
                     stat_nxt[ST_TFB] = stat_r[ST_TFB] ^ dmem_tag;
                  end else begin
                     stat_nxt[ST_TFA] = stat_r[ST_TFA] ^ dmem_tag;
                  end
                  pc_nxt = pc_r + ONE_WORD;
               end
               done_nxt = 1'b1;
               st_nxt = ST_IDLE;
            end
         end
         ST_VDAT: begin
            if (ce) begin
               pc_nxt = pmem_rdata;
               done_nxt = 1'b1;
               st_nxt = ST_IDLE;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   // all state registers; clock enable freezes everything, strobes included
   always_ff @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         st_r <= ST_IDLE;
         pc_r <= PC_RST;
         stat_r <= STAT_RST;
         result_r <= REG_RST;
         opa_r <= REG_RST;
         pw_r <= ONE_WORD;
         kind_r <= K_MEM;
         dst_r <= PT_RST;
         tfs_r <= 1'b0;
         busy_r <= 1'b0;
         done_r <= 1'b0;
         sign_ext_mode_r <= 1'b0;
         pmem_addr_r <= REG_RST;
         pmem_rd_r <= 1'b0;
         dmem_addr_r <= REG_RST;
         dmem_rd_r <= 1'b0;
         dmem_wr_r <= 1'b0;
         dmem_wdata_r <= REG_RST;
         for (int i = 0; i < NACC; i++) acc_r[i] <= REG_RST;
         for (int i = 0; i < NREG; i++) rx_r[i] <= REG_RST;
         for (int i = 0; i < 4; i++) pt_r[i] <= PT_RST;
      end else if (ce) begin
         st_r <= st_nxt;
         pc_r <= pc_nxt;
         stat_r <= stat_nxt;
         result_r <= result_nxt;
         opa_r <= opa_nxt;
         pw_r <= pw_nxt;
         kind_r <= kind_nxt;
         dst_r <= dst_nxt;
         tfs_r <= tfs_nxt;
         busy_r <= (st_nxt != ST_IDLE);
         done_r <= done_nxt;
         sign_ext_mode_r <= stat_nxt[ST_SX];
         pmem_addr_r <= pmem_addr_nxt;
         pmem_rd_r <= pmem_rd_nxt;
         dmem_addr_r <= dmem_addr_nxt;
         dmem_rd_r <= dmem_rd_nxt;
         dmem_wr_r <= dmem_wr_nxt;
         dmem_wdata_r <= dmem_wdata_nxt;
         if (acc_we) acc_r[acc_wa] <= acc_wd;
         if (rx_we) rx_r[rx_wa] <= rx_wd;
         if (pt_we) pt_r[pt_wa] <= pt_wd;
      end
   end

   // checks on the executed results
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);

   a_set_sign_mode: assert property (accept && instr_word == SET_SX_OPC |=>
      stat_r[ST_SX] && done_r && stat_r[5:1] == $past(stat_r[5:1]))
      else $error("set sign mode did not set bit 0 cleanly");
   a_sign_mode_out: assert property (ce ##1 1 |-> sign_ext_mode_r == stat_r[ST_SX])
      else $error("sign extension output differs from status bit");
   a_sign_mode_hold: assert property ($changed(sign_ext_mode_r) |->
      $past(accept && (instr_word == SET_SX_OPC || instr_word == CLR_SX_OPC)))
      else $error("sign extension mode moved without a sign mode instruction");
   a_vectored_call_instr_stack: assert property (accept && instr_word[16:8] == VECTORED_CALL_INSTR_PFX |=>
      dmem_wr_r && dmem_wdata_r == $past(pc_r) + ONE_WORD
      && rx_r[SP_IDX] == $past(rx_r[SP_IDX]) + SP_STEP)
      else $error("vectored call push or stack step wrong");
   a_vectored_call_instr_vector: assert property (accept && instr_word[16:8] == VECTORED_CALL_INSTR_PFX |=>
      pmem_rd_r && pmem_addr_r == VEC_BASE + {8'h00, $past(instr_word[7:0])})
      else $error("vectored call table address wrong");
   a_vectored_call_instr_target: assert property (ce && st_r == ST_VDAT |=>
      pc_r == $past(pmem_rdata) && done_r)
      else $error("vectored call target not loaded");
   a_xor_imm_words: assert property (accept && instr_word[16:12] == XACC_PFX
      && instr_word[7:2] == XIMM_SUB |=> pc_r == $past(pc_r) + TWO_WORDS && done_r)
      else $error("immediate xor did not step two words");
   a_xor_flags: assert property (done_r && $past(st_r) == ST_MDAT && $past(kind_r) == K_MEM
      |-> stat_r[ST_ZER] == (result_r == 16'h0000) && stat_r[ST_SGN] == result_r[15]
      && !stat_r[ST_CRY] && stat_r[ST_TAG] == $past(dmem_tag))
      else $error("memory xor flags wrong");
   a_index_zero: assert property (accept && instr_word[16:12] == XTFC_PFX
      && instr_word[1:0] == XTFC_SUB && cc == CC_RZ && !instr_word[11] && !instr_word[10]
      |=> stat_r[ST_TFA] == ($past(stat_r[ST_TFA]) ^ ($past(rx_r[rsel]) == 16'h0000)))
      else $error("index zero test wrong");
   a_post_dec: assert property (accept && instr_word[16:10] == XMEM_PFX
      && am == AM_POSTDEC |=> rx_r[$past(rb)] == $past(rx_r[rb]) - POST_STEP)
      else $error("post decrement step wrong");
   a_indexed_keep: assert property (accept && instr_word[16:10] == XMEM_PFX
      && am == AM_INDEXED |=> rx_r[$past(rb)] == $past(rx_r[rb])
      && dmem_addr_r == $past(rx_r[rb]) + $past(rx_r[OFS_IDX]))
      else $error("indexed operand moved its base");
endmodule : sve_exec

// *** sve_mem_model.sv ***
// behavioural program and data memory on the far side of the executor
`timescale 1ns/1ps
module sve_mem_model (
   input  wire logic        clock,
   input  wire logic [15:0] pmem_addr_r,
   input  wire logic        pmem_rd_r,
   input  wire logic [15:0] dmem_addr_r,
   input  wire logic        dmem_rd_r,
   output logic      [15:0] pmem_rdata,
   output logic      [15:0] dmem_rdata,
   output logic             dmem_tag
);
   // known start so the toggling filler below is never unknown
   initial begin
      pmem_rdata = 16'h0000;
      dmem_rdata = 16'h0000;
      dmem_tag   = 1'b0;
   end
   // answer only in the cycle after a strobe; otherwise toggle so stale data never looks valid
   always @(posedge clock) begin
      pmem_rdata <= pmem_rd_r ? (pmem_addr_r ^ 16'h3c5a) : ~pmem_rdata;
      dmem_rdata <= dmem_rd_r ? (dmem_addr_r ^ 16'ha5c3) : ~dmem_rdata;
      dmem_tag   <= dmem_rd_r ? ^dmem_addr_r[3:0] : ~dmem_tag;
   end
endmodule : sve_mem_model

// *** sign_mode_vectored_call_instr_xor_exec_test.sv ***
// self-checking bench for the sign-mode / vectored-call / xor executor
`timescale 1ns/1ps
module sign_mode_vectored_call_instr_xor_exec_test
   import sve_pkg::*;
;
   typedef struct packed {logic [16:0] w; logic [15:0] x;} sve_row_t;
   logic        clock, arst_n, ce, instr_valid, dmem_tag, busy_r, done_r;
   logic        sign_ext_mode_r, pmem_rd_r, dmem_rd_r, dmem_wr_r;
   logic [16:0] instr_word;
   logic [15:0] instr_ext, pmem_rdata, dmem_rdata, pc_r, stat_r, result_r;
   logic [15:0] pmem_addr_r, dmem_addr_r, dmem_wdata_r;
   // reference copy of the programmer-visible state
   logic [15:0] acc_m [NACC];
   logic [4:0]  pt_m [4];
   logic [15:0] rx_m [NREG];
   logic [15:0] stat_m, pc_m, res_m, ea_m, psh_m, dat_m;
   int          kind_m, errors, checks_done;
   sve_row_t    rows [$];

   sve_exec DUT (.clock(clock), .arst_n(arst_n), .ce(ce), .instr_valid(instr_valid),
      .instr_word(instr_word), .instr_ext(instr_ext), .pmem_rdata(pmem_rdata),
      .dmem_rdata(dmem_rdata), .dmem_tag(dmem_tag), .busy_r(busy_r), .done_r(done_r),
      .pc_r(pc_r), .stat_r(stat_r), .sign_ext_mode_r(sign_ext_mode_r), .result_r(result_r),
      .pmem_addr_r(pmem_addr_r), .pmem_rd_r(pmem_rd_r), .dmem_addr_r(dmem_addr_r),
      .dmem_rd_r(dmem_rd_r), .dmem_wr_r(dmem_wr_r), .dmem_wdata_r(dmem_wdata_r));
   sve_mem_model mem (.clock(clock), .pmem_addr_r(pmem_addr_r), .pmem_rd_r(pmem_rd_r),
      .dmem_addr_r(dmem_addr_r), .dmem_rd_r(dmem_rd_r), .pmem_rdata(pmem_rdata),
      .dmem_rdata(dmem_rdata), .dmem_tag(dmem_tag));

   // 4 ns core clock
   initial clock = 1'b0;
   always #2 clock = ~clock;

   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         errors++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic close_out;
      if (errors == 0 && checks_done > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask : close_out

   task automatic model_reset;
      foreach (acc_m[i]) acc_m[i] = REG_RST;
      foreach (pt_m[i]) pt_m[i] = PT_RST;
      foreach (rx_m[i]) rx_m[i] = REG_RST;
      stat_m = STAT_RST;
      pc_m   = PC_RST;
      res_m  = 16'h0000;
   endtask : model_reset

   task automatic rst_check;
      check("rst_pc", pc_r, PC_RST);
      check("rst_stat", stat_r, STAT_RST);
      check("rst_busy", busy_r, 1'b0);
      check("rst_done", done_r, 1'b0);
   endtask : rst_check

   function automatic logic cond_of(input logic [4:0] cc, input logic [15:0] rv);
      case (cc)
         CC_TRUE: return 1'b1;
         CC_CRY:  return stat_m[ST_CRY];
         CC_ZER:  return stat_m[ST_ZER];
         CC_SGN:  return stat_m[ST_SGN];
         CC_OVF:  return stat_m[ST_OVF];
         CC_TAG:  return stat_m[ST_TAG];
         CC_RZ:   return rv == 16'h0000;
         CC_RNZ:  return rv != 16'h0000;
         CC_RN:   return rv[15];
         CC_RNN:  return !rv[15];
         default: return 1'b0;
      endcase
   endfunction : cond_of

   // advance the reference state by one instruction
   task automatic model(input logic [16:0] w, input logic [15:0] x);
      logic [4:0] p;
      logic [2:0] r;
      kind_m = 0;
      r = w[2:0];
      p = pt_m[w[9:8]];
      if (w == SET_SX_OPC || w == CLR_SX_OPC) begin
         stat_m[ST_SX] = (w == SET_SX_OPC);
         pc_m = pc_m + ONE_WORD;
      end else if (w[16:8] == VECTORED_CALL_INSTR_PFX) begin
         kind_m = 2;
         ea_m = VEC_BASE + {8'h00, w[7:0]};
         psh_m = rx_m[SP_IDX];
         dat_m = pc_m + ONE_WORD;
         rx_m[SP_IDX] = psh_m + SP_STEP;
         pc_m = ea_m ^ 16'h3c5a;
      end else if (w[16:10] == XMEM_PFX) begin
         kind_m = 1;
         ea_m = (w[7:5] == AM_DIRECT) ? x : rx_m[r];
         if (w[7:5] == AM_INDEXED) ea_m = rx_m[r] + rx_m[OFS_IDX];
         if (w[7:5] == AM_POSTINC) rx_m[r] = rx_m[r] + POST_STEP;
         if (w[7:5] == AM_POSTDEC) rx_m[r] = rx_m[r] - POST_STEP;
         res_m = acc_m[p] ^ ea_m ^ 16'ha5c3;
         acc_m[p] = res_m;
         stat_m[ST_TAG] = ^ea_m[3:0];
         stat_m[ST_CRY:ST_OVF] = {1'b0, res_m == 16'h0000, res_m[15], 1'b0};
         pc_m = pc_m + ((w[7:5] == AM_DIRECT) ? TWO_WORDS : ONE_WORD);
      end else if (w[16:12] == XACC_PFX) begin
         if (w[11:10] == NXT_INC) p = p + 5'h01;
         if (w[11:10] == NXT_DEC) p = p - 5'h01;
         pt_m[w[9:8]] = p;
         res_m = acc_m[p] ^ acc_m[p ^ ACC_OFS];
         if (w[7:2] == XIMM_SUB) res_m = acc_m[w[1] ? p ^ ACC_OFS : p] ^ x;
         acc_m[w[0] ? p ^ ACC_OFS : p] = res_m;
         stat_m[ST_CRY:ST_OVF] = {1'b0, res_m == 16'h0000, res_m[15], 1'b0};
         pc_m = pc_m + ((w[7:2] == XIMM_SUB) ? TWO_WORDS : ONE_WORD);
      end else if (w[16:12] == XTFM_PFX) begin
         kind_m = 1;
         ea_m = {9'h000, w[6:0]};
         stat_m[ST_TFA + w[11]] = stat_m[ST_TFA + w[11]] ^ ^ea_m[3:0];
         pc_m = pc_m + ONE_WORD;
      end else begin
         stat_m[ST_TFA + w[11]] = stat_m[ST_TFA + w[11]] ^ cond_of(w[9:5], rx_m[w[4:2]]) ^ w[10];
         pc_m = pc_m + ONE_WORD;
      end
   endtask : model

   // one instruction; keep holds a set-sign request up while busy, which must be ignored
   task automatic issue(input logic [16:0] w, input logic [15:0] x, input bit keep);
      int n;
      model(w, x);
      @(posedge clock);
      instr_word  <= w;
      instr_ext   <= x;
      instr_valid <= 1'b1;
      @(posedge clock);
      if (keep) instr_word <= SET_SX_OPC;
      else instr_valid <= 1'b0;
      #1;
      if (kind_m == 1) begin
         check("dmem_rd", dmem_rd_r, 1'b1);
         check("dmem_addr", dmem_addr_r, ea_m);
      end
      if (kind_m == 2) begin
         check("push_wr", dmem_wr_r, 1'b1);
         check("push_addr", dmem_addr_r, psh_m);
         check("push_data", dmem_wdata_r, dat_m);
         check("vec_rd", pmem_rd_r, 1'b1);
         check("vec_addr", pmem_addr_r, ea_m);
      end
      n = 0;
      while (done_r !== 1'b1 && n < 6) begin
         @(posedge clock);
         n++;
         if (n == 2) instr_valid <= 1'b0;
         #1;
      end
      if (done_r !== 1'b1) begin
         errors++;
         close_out();
      end
      check("latency", 16'(n), (kind_m == 0) ? 16'h0000 : 16'h0002);
      check("pc", pc_r, pc_m);
      check("stat", stat_r, stat_m);
      check("result", result_r, res_m);
      check("sign_mode", sign_ext_mode_r, stat_m[ST_SX]);
   endtask : issue

   initial begin
      arst_n      = 1'b0;
      ce          = 1'b1;
      instr_valid = 1'b0;
      instr_word  = 17'h0_0000;
      instr_ext   = 16'h0000;
      errors      = 0;
      checks_done = 0;
      model_reset();
      rows.push_back(sve_row_t'{SET_SX_OPC, 16'h0000});
      rows.push_back(sve_row_t'{{XACC_PFX, 2'h0, 2'h0, XIMM_SUB, 2'b00}, 16'h13ff});
      rows.push_back(sve_row_t'{{XACC_PFX, NXT_INC, 2'h0, XIMM_SUB, 2'b00}, 16'h0002});
      rows.push_back(sve_row_t'{{XACC_PFX, 2'h0, 2'h1, XAA_SUB, 2'b00}, 16'h0000});
      rows.push_back(sve_row_t'{{XACC_PFX, NXT_DEC, 2'h0, XIMM_SUB, 2'b11}, 16'h8000});
      rows.push_back(sve_row_t'{{XACC_PFX, NXT_INC, 2'h3, XIMM_SUB, 2'b00}, 16'h0002});
      rows.push_back(sve_row_t'{{XMEM_PFX, 2'h1, AM_DIRECT, 5'h00}, 16'h0040});
      rows.push_back(sve_row_t'{{XMEM_PFX, 2'h2, AM_IND, 5'h03}, 16'h0000});
      rows.push_back(sve_row_t'{{XMEM_PFX, 2'h0, AM_POSTINC, 5'h05}, 16'h0000});
      rows.push_back(sve_row_t'{{XMEM_PFX, 2'h3, AM_POSTDEC, 5'h02}, 16'h0000});
      rows.push_back(sve_row_t'{{XMEM_PFX, 2'h1, AM_INDEXED, 5'h02}, 16'h0000});
      rows.push_back(sve_row_t'{{XMEM_PFX, 2'h1, AM_IND, 5'h02}, 16'h0000});
      rows.push_back(sve_row_t'{{XTFM_PFX, 2'b00, XTFM_SUB, 7'h21}, 16'h0000});
      rows.push_back(sve_row_t'{{XTFM_PFX, 2'b10, XTFM_SUB, 7'h17}, 16'h0000});
      // every condition code; an index register only beside the index conditions
      for (int c = 0; c < 11; c++) begin
         rows.push_back(sve_row_t'{{XTFC_PFX, c[0], c[1], c[4:0],
            (c > 5 && c < 10) ? 3'h2 : 3'h0, XTFC_SUB}, 16'h0000});
      end
      rows.push_back(sve_row_t'{{XTFC_PFX, 2'b00, CC_RZ, 3'h3, XTFC_SUB}, 16'h0000});
      // no return follows a vectored call in this stream
      rows.push_back(sve_row_t'{{VECTORED_CALL_INSTR_PFX, 8'h02}, 16'h0000});
      rows.push_back(sve_row_t'{{VECTORED_CALL_INSTR_PFX, 8'hff}, 16'h0000});
      rows.push_back(sve_row_t'{CLR_SX_OPC, 16'h0000});
      repeat (5) @(posedge clock);
      #1;
      rst_check();
      @(posedge clock);
      arst_n <= 1'b1;
      foreach (rows[i]) issue(rows[i].w, rows[i].x, 1'b0);
      // set-sign request held while busy must not be taken
      issue({VECTORED_CALL_INSTR_PFX, 8'h10}, 16'h0000, 1'b1);
      // clock enable low freezes everything, then the held request is taken
      @(posedge clock);
      ce          <= 1'b0;
      instr_word  <= SET_SX_OPC;
      instr_valid <= 1'b1;
      repeat (3) @(posedge clock);
      #1;
      check("frozen_stat", stat_r, stat_m);
      check("frozen_done", done_r, 1'b0);
      model(SET_SX_OPC, 16'h0000);
      @(posedge clock);
      ce <= 1'b1;
      @(posedge clock);
      instr_valid <= 1'b0;
      #1;
      check("ce_stat", stat_r, stat_m);
      check("ce_pc", pc_r, pc_m);
      // reset in mid-run clears the stack pointer too
      @(posedge clock);
      arst_n <= 1'b0;
      #1;
      rst_check();
      model_reset();
      @(posedge clock);
      arst_n <= 1'b1;
      issue({VECTORED_CALL_INSTR_PFX, 8'h00}, 16'h0000, 1'b0);
      close_out();
   end
endmodule : sign_mode_vectored_call_instr_xor_exec_test
